// >>> design/pdlc_params.svh
/*
  Offsets, field positions, reset values and timing counts for the PHY
  diagnostic, transceiver gain and indicator configuration registers.
  Assumes inclusion by bare name from the design files.
*/
`ifndef PDLC_PARAMS_SVH
`define PDLC_PARAMS_SVH

// ----------------------------------------------------------------------
// Management addresses
// ----------------------------------------------------------------------
`define PDLC_ADDR_W 5
`define PDLC_DATA_W 16
`define PDLC_ADDR_DIAG 5'h12
`define PDLC_ADDR_GAIN 5'h13
`define PDLC_ADDR_LEDCFG 5'h17

// ----------------------------------------------------------------------
// Reset values
// ----------------------------------------------------------------------
`define PDLC_RST_DIAG 16'h0000
`define PDLC_RST_GAIN 16'h4000
`define PDLC_RST_LEDCFG 16'h0010

// ----------------------------------------------------------------------
// Field positions
// ----------------------------------------------------------------------
`define PDLC_BIT_FAIL 12
`define PDLC_BIT_DUPLEX 11
`define PDLC_BIT_RATE 10
`define PDLC_BIT_RXDET 9
`define PDLC_BIT_LOCK 8
`define PDLC_SECOND_MSB 7
`define PDLC_SECOND_LSB 4
`define PDLC_FIRST_MSB 3
`define PDLC_FIRST_LSB 0

// ----------------------------------------------------------------------
// Timing
// ----------------------------------------------------------------------
`define PDLC_CLK_NS 25
`define PDLC_BLINK_NS 50000000
`define PDLC_BLINK_CYCLES ((`PDLC_BLINK_NS + `PDLC_CLK_NS - 1) / `PDLC_CLK_NS)

`endif

// >>> design/pdlc_pkg.sv
/*
  Types shared by the PHY diagnostic and indicator register bank.
  Assumes nothing beyond a SystemVerilog compiler.
*/
package pdlc_pkg;

  // ----------------------------------------------------------------------
  // Indicator source codes
  // ----------------------------------------------------------------------
  typedef enum logic [3:0] {
    PDLC_SRC_LINK     = 4'h0,
    PDLC_SRC_ACT      = 4'h1,
    PDLC_SRC_100      = 4'h5,
    PDLC_SRC_10       = 4'h6,
    PDLC_SRC_FDX      = 4'h7,
    PDLC_SRC_LINK_ACT = 4'h8
  } pdlc_src_e;

  typedef logic [15:0] pdlc_word_t;

endpackage

// >>> design/pdlc_regs.sv
/*
  Management register bank of the PHY: diagnostic result of the last
  auto-negotiation, transmit gain control and indicator source selection,
  plus the two indicator outputs.
  Assumes a management engine in front that presents one-cycle read and
  write strobes with an address, and status inputs synchronous to clk_i.
*/
// Behaviour
// - A negotiation that ends with no common technology sets the failure flag in bit 12.
// - The failure flag stays set until software reads the diagnostic register, which clears it.
// - Bit 11 shows full duplex as the negotiated best mode, low for half duplex.
// - Bit 10 shows 100 Mb/s as the negotiated best speed, low for 10 Mb/s.
// - Bit 9 shows that a receive signal or Manchester data has been detected.
// - Bit 8 shows that the receive PLL is locked at the selected speed.
// - The diagnostic register lives at 0x12, is read-only apart from the flag, and resets to zero.
// - The gain control register at 0x13 is read-write and resets to 0x4000.
// - The indicator configuration register at 0x17 is read-write and resets to 0x0010.
// - Bits 7:4 pick the second indicator source and reset to activity.
// - Bits 3:0 pick the first indicator source and reset to link good.
// - Source codes are 0 link, 1 activity, 5 100 Mb/s, 6 10 Mb/s, 7 full duplex.
// - Source code 8 lights on link good and blinks off on activity.
// - All registers can be polled over the management port at their addresses.
`timescale 1ns/100ps
`default_nettype none
`include "pdlc_params.svh"

module pdlc_regs #(
  parameter int unsigned BLINK_CYCLES = `PDLC_BLINK_CYCLES
) (
  // Clock and reset.
  input wire logic clk_i,
  input wire logic resetn_i,
  // Management register port.
  input wire logic rd_en_i,
  input wire logic wr_en_i,
  input wire logic [`PDLC_ADDR_W-1:0] addr_i,
  input wire pdlc_pkg::pdlc_word_t wr_data_i,
  output var pdlc_pkg::pdlc_word_t rd_data_o,
  output logic rd_valid_o,
  // Negotiation result and receive status.
  input wire logic neg_done_i,
  input wire logic neg_fail_i,
  input wire logic neg_full_duplex_i,
  input wire logic neg_speed100_i,
  input wire logic receive_signal_detected_i,
  input wire logic rx_pll_lock_i,
  // Link state for the indicators.
  input wire logic link_good_i,
  input wire logic activity_i,
  // Transceiver controls and indicators.
  output var pdlc_pkg::pdlc_word_t tx_gain_o,
  output logic first_led_o,
  output logic second_led_o
);
  import pdlc_pkg::*;

  localparam int unsigned CNT_W = $clog2(BLINK_CYCLES + 1);
  localparam pdlc_word_t LEDCFG_RST = `PDLC_RST_LEDCFG;

  logic negotiation_failed_flag_ff, nxt_negotiation_failed_flag;
  logic full_duplex_result_ff, nxt_full_duplex_result;
  logic rate100_ff, nxt_rate100;
  logic receive_signal_detected_ff, nxt_receive_signal_detected;
  logic pll_lock_ff, nxt_pll_lock;
  pdlc_word_t gain_ff, nxt_gain;
  logic [3:0] first_indicator_source_ff, nxt_first_indicator_source;
  logic [3:0] second_indicator_source_ff, nxt_second_indicator_source;
  pdlc_word_t rd_data_ff, nxt_rd_data;
  logic rd_valid_ff, nxt_rd_valid;
  logic [CNT_W-1:0] act_cnt_ff, nxt_act_cnt;
  logic first_led_ff, nxt_first_led;
  logic second_led_ff, nxt_second_led;
  logic chk_live_ff, nxt_chk_live;
  logic rd_diag, wr_gain, wr_led;
  logic act_on;
  pdlc_word_t diag_word;

  // ----------------------------------------------------------------------
  // Address decode and register images
  // ----------------------------------------------------------------------

  // Strobes per register and the assembled diagnostic word.
  assign rd_diag = rd_en_i && (addr_i == `PDLC_ADDR_DIAG);
  assign wr_gain = wr_en_i && (addr_i == `PDLC_ADDR_GAIN);
  assign wr_led = wr_en_i && (addr_i == `PDLC_ADDR_LEDCFG);
  assign act_on = (act_cnt_ff != '0);
  always_comb begin
    diag_word = `PDLC_RST_DIAG;
    diag_word[`PDLC_BIT_FAIL] = negotiation_failed_flag_ff;
    diag_word[`PDLC_BIT_DUPLEX] = full_duplex_result_ff;
    diag_word[`PDLC_BIT_RATE] = rate100_ff;
    diag_word[`PDLC_BIT_RXDET] = receive_signal_detected_ff;
    diag_word[`PDLC_BIT_LOCK] = pll_lock_ff;
  end

  // Maps a source code onto the indicator level; reserved codes stay dark.
  function automatic logic led_level(input logic [3:0] code, input logic link,
                                     input logic act);
    case (code)
      PDLC_SRC_LINK: led_level = link;
      PDLC_SRC_ACT: led_level = act;
      PDLC_SRC_100: led_level = rate100_ff;
      PDLC_SRC_10: led_level = ~rate100_ff;
      PDLC_SRC_FDX: led_level = full_duplex_result_ff;
      PDLC_SRC_LINK_ACT: led_level = link & ~act;
      default: led_level = 1'b0;
    endcase
  endfunction

  // ----------------------------------------------------------------------
  // Next-state logic
  // ----------------------------------------------------------------------

  // Computes every register's next value; a failure event wins over the read clear.
  always_comb begin
    nxt_negotiation_failed_flag = negotiation_failed_flag_ff;
    if (rd_diag) begin
      nxt_negotiation_failed_flag = 1'b0;
    end
    if (neg_done_i && neg_fail_i) begin
      nxt_negotiation_failed_flag = 1'b1;
    end
    nxt_full_duplex_result = full_duplex_result_ff;
    nxt_rate100 = rate100_ff;
    if (neg_done_i) begin
      nxt_full_duplex_result = neg_full_duplex_i;
      nxt_rate100 = neg_speed100_i;
    end
    nxt_receive_signal_detected = receive_signal_detected_i;
    nxt_pll_lock = rx_pll_lock_i;
    nxt_chk_live = 1'b1; // Arms the checks one edge after reset release.
    nxt_gain = wr_gain ? wr_data_i : gain_ff;
    nxt_first_indicator_source = first_indicator_source_ff;
    nxt_second_indicator_source = second_indicator_source_ff;
    if (wr_led) begin
      nxt_first_indicator_source = wr_data_i[`PDLC_FIRST_MSB:`PDLC_FIRST_LSB];
      nxt_second_indicator_source = wr_data_i[`PDLC_SECOND_MSB:`PDLC_SECOND_LSB];
    end
    nxt_rd_valid = rd_en_i;
    nxt_rd_data = rd_data_ff;
    if (rd_en_i) begin
      case (addr_i)
        `PDLC_ADDR_DIAG: nxt_rd_data = diag_word;
        `PDLC_ADDR_GAIN: nxt_rd_data = gain_ff;
        `PDLC_ADDR_LEDCFG: nxt_rd_data = {8'h00, second_indicator_source_ff,
                                          first_indicator_source_ff};
        default: nxt_rd_data = 16'h0000;
      endcase
    end
    if (activity_i) begin
      nxt_act_cnt = CNT_W'(BLINK_CYCLES);
    end else if (act_on) begin
      nxt_act_cnt = act_cnt_ff - CNT_W'(1);
    end else begin
      nxt_act_cnt = act_cnt_ff;
    end
    nxt_first_led = led_level(first_indicator_source_ff, link_good_i, act_on);
    nxt_second_led = led_level(second_indicator_source_ff, link_good_i, act_on);
  end

  // Registers all state.
  always_ff @(posedge clk_i or negedge resetn_i) begin
    if (!resetn_i) begin
      negotiation_failed_flag_ff <= 1'b0;
      full_duplex_result_ff <= 1'b0;
      rate100_ff <= 1'b0;
      receive_signal_detected_ff <= 1'b0;
      pll_lock_ff <= 1'b0;
      gain_ff <= `PDLC_RST_GAIN;
      first_indicator_source_ff <= LEDCFG_RST[`PDLC_FIRST_MSB:`PDLC_FIRST_LSB];
      second_indicator_source_ff <= LEDCFG_RST[`PDLC_SECOND_MSB:`PDLC_SECOND_LSB];
      rd_data_ff <= 16'h0000;
      rd_valid_ff <= 1'b0;
      act_cnt_ff <= '0;
      first_led_ff <= 1'b0;
      second_led_ff <= 1'b0;
      chk_live_ff <= 1'b0;
    end else begin
      negotiation_failed_flag_ff <= nxt_negotiation_failed_flag;
      full_duplex_result_ff <= nxt_full_duplex_result;
      rate100_ff <= nxt_rate100;
      receive_signal_detected_ff <= nxt_receive_signal_detected;
      pll_lock_ff <= nxt_pll_lock;
      gain_ff <= nxt_gain;
      first_indicator_source_ff <= nxt_first_indicator_source;
      second_indicator_source_ff <= nxt_second_indicator_source;
      rd_data_ff <= nxt_rd_data;
      rd_valid_ff <= nxt_rd_valid;
      act_cnt_ff <= nxt_act_cnt;
      first_led_ff <= nxt_first_led;
      second_led_ff <= nxt_second_led;
      chk_live_ff <= nxt_chk_live;
    end
  end

  // Outputs straight from flip-flops.
  assign rd_data_o = rd_data_ff;
  assign rd_valid_o = rd_valid_ff;
  assign tx_gain_o = gain_ff;
  assign first_led_o = first_led_ff;
  assign second_led_o = second_led_ff;

  // ----------------------------------------------------------------------
  // Assertions
  // ----------------------------------------------------------------------
  default clocking cb @(posedge clk_i); endclocking
  // Checks start one edge after release, so the edge that leaves reset is not judged.
  default disable iff (!resetn_i || !chk_live_ff);

  a_fail_sets: assert property (
    neg_done_i && neg_fail_i |=> negotiation_failed_flag_ff)
    else $error("failure flag not set");
  a_fail_holds: assert property (
    negotiation_failed_flag_ff && !rd_diag |=> negotiation_failed_flag_ff)
    else $error("failure flag dropped");
  a_fail_read_clr: assert property (
    rd_diag && !(neg_done_i && neg_fail_i) |=> !negotiation_failed_flag_ff && rd_valid_o)
    else $error("read did not clear");
  a_duplex_latch: assert property (
    neg_done_i |=> full_duplex_result_ff == $past(neg_full_duplex_i))
    else $error("duplex bit bad");
  a_rate_latch: assert property (
    neg_done_i |=> rate100_ff == $past(neg_speed100_i))
    else $error("rate bit bad");
  a_rxdet_read: assert property (
    rd_diag |=> rd_data_o[`PDLC_BIT_RXDET] == $past(receive_signal_detected_ff))
    else $error("receive detect bit bad");
  a_lock_read: assert property (
    rd_diag |=> rd_data_o[`PDLC_BIT_LOCK] == $past(rx_pll_lock_i, 2))
    else $error("lock bit bad");
  a_diag_rsv: assert property (
    rd_diag |=> rd_valid_o && rd_data_o[15:13] == 3'h0 && rd_data_o[7:0] == 8'h00)
    else $error("diagnostic reserved bits set");
  a_gain_write: assert property (
    wr_gain |=> tx_gain_o == $past(wr_data_i))
    else $error("gain write lost");
  a_ledcfg_rsv: assert property (
    rd_en_i && addr_i == `PDLC_ADDR_LEDCFG |=> rd_data_o[15:8] == 8'h00)
    else $error("config reserved bits set");
  a_led_link: assert property (
    first_indicator_source_ff == 4'h0 |=> first_led_o == $past(link_good_i))
    else $error("link indicator bad");
  a_led_blink: assert property (
    first_indicator_source_ff == 4'h8 && act_on |=> !first_led_o)
    else $error("blink indicator bad");
  a_led_resv: assert property (
    first_indicator_source_ff inside {4'h2, 4'h3, 4'h4} |=> !first_led_o)
    else $error("reserved code lit");

  c_fail_read: cover property (negotiation_failed_flag_ff ##1 rd_diag ##1
    !negotiation_failed_flag_ff);
  c_set_and_clr: cover property (rd_diag && neg_done_i && neg_fail_i);
  c_blink: cover property (first_indicator_source_ff == 4'h8 && link_good_i &&
    activity_i);
  c_gain_rw: cover property (wr_gain ##2 rd_en_i && addr_i == `PDLC_ADDR_GAIN);

endmodule
`default_nettype wire

// >>> sim/pdlc_regs_test.sv
/*
  Self-checking bench for the PHY diagnostic and indicator register bank.
  Assumes pdlc_pkg and pdlc_regs are compiled first; the bench drives all ports.
*/
`timescale 1ns/100ps
`default_nettype none

module pdlc_regs_test;
  import pdlc_pkg::*;

  // --------------------------------------------------------------------
  // Signals, table and counters
  // --------------------------------------------------------------------
  typedef struct packed {logic [4:0] a; pdlc_word_t d; pdlc_word_t x;} pdlc_row_s;
  localparam int BLINK = 8;
  localparam logic [8:0] LED_MAP = 9'h1c1;
  pdlc_row_s rows [5] = '{'{5'h13, 16'hbeef, 16'hbeef}, '{5'h17, 16'hfff6, 16'h00f6},
    '{5'h12, 16'hffff, 16'h0000}, '{5'h05, 16'h1234, 16'h0000}, '{5'h17, 16'h0078, 16'h0078}};
  logic clk_i = 1'b0;
  logic resetn_i = 1'b0;
  logic rd_en_i = 1'b0;
  logic wr_en_i = 1'b0;
  logic [4:0] addr_i = 5'h00;
  pdlc_word_t wr_data_i = 16'h0000;
  logic neg_done_i = 1'b0;
  logic neg_fail_i = 1'b0;
  logic neg_fdx_i = 1'b0;
  logic neg_spd_i = 1'b0;
  logic rsd_i = 1'b0;
  logic lock_i = 1'b0;
  logic link_good_i = 1'b1;
  logic activity_i = 1'b0;
  pdlc_word_t rd_data_o;
  pdlc_word_t tx_gain_o;
  logic rd_valid_o;
  logic first_led_o;
  logic second_led_o;
  int num_errors = 0;
  int cmp_count = 0;
  int cycles = 0;

  // Clock of 25 ns period.
  always #12.5 clk_i = ~clk_i;

  pdlc_regs #(.BLINK_CYCLES(BLINK)) dut_u (.clk_i(clk_i), .resetn_i(resetn_i),
    .rd_en_i(rd_en_i), .wr_en_i(wr_en_i), .addr_i(addr_i), .wr_data_i(wr_data_i),
    .rd_data_o(rd_data_o), .rd_valid_o(rd_valid_o), .neg_done_i(neg_done_i),
    .neg_fail_i(neg_fail_i), .neg_full_duplex_i(neg_fdx_i), .neg_speed100_i(neg_spd_i),
    .receive_signal_detected_i(rsd_i), .rx_pll_lock_i(lock_i), .link_good_i(link_good_i),
    .activity_i(activity_i), .tx_gain_o(tx_gain_o), .first_led_o(first_led_o),
    .second_led_o(second_led_o));

  // --------------------------------------------------------------------
  // Tasks
  // --------------------------------------------------------------------
  // Compares one word and counts the result.
  task automatic chk(input pdlc_word_t got, input pdlc_word_t exp);
    cmp_count++;
    if (got !== exp) begin
      num_errors++;
      $display("Error at %0t: got %h expected %h", $time, got, exp);
    end
  endtask

  // One-cycle write strobe.
  task automatic wr(input logic [4:0] a, input pdlc_word_t d);
    @(posedge clk_i);
    wr_en_i <= 1'b1;
    addr_i <= a;
    wr_data_i <= d;
    @(posedge clk_i);
    wr_en_i <= 1'b0;
  endtask

  // One-cycle read strobe; the answer is due one cycle later.
  task automatic rd(input logic [4:0] a, input pdlc_word_t x);
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i <= a;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    #1;
    chk({15'h0000, rd_valid_o}, 16'h0001);
    chk(rd_data_o, x);
  endtask

  // One negotiation result pulse.
  task automatic neg(input logic f, input logic d, input logic s);
    @(posedge clk_i);
    neg_done_i <= 1'b1;
    neg_fail_i <= f;
    neg_fdx_i <= d;
    neg_spd_i <= s;
    @(posedge clk_i);
    neg_done_i <= 1'b0;
  endtask

  // Prints the counts and the verdict, then stops.
  task automatic close_out();
    $display("Compares %0d, mismatches %0d", cmp_count, num_errors);
    if (num_errors == 0 && cmp_count > 0) begin
      $display("NO MISMATCHES");
    end else begin
      $display("MISMATCHES SEEN");
    end
    $finish;
  endtask

  // Cuts a hang short.
  always @(posedge clk_i) begin
    cycles <= cycles + 1;
    if (cycles == 4000) begin
      num_errors++;
      $display("Error at %0t: run timed out", $time);
      close_out();
    end
  end

  // --------------------------------------------------------------------
  // Test sequence
  // --------------------------------------------------------------------
  initial begin
    repeat (12) @(posedge clk_i);
    resetn_i <= 1'b1;
    repeat (2) @(posedge clk_i);
    #1;
    chk(tx_gain_o, 16'h4000);
    chk({14'h0000, second_led_o, first_led_o}, 16'h0001);
    rd(5'h12, 16'h0000);
    rd(5'h13, 16'h4000);
    rd(5'h17, 16'h0010);
    $display("reset test done");
    foreach (rows[i]) begin
      wr(rows[i].a, rows[i].d);
      rd(rows[i].a, rows[i].x);
    end
    chk(tx_gain_o, 16'hbeef);
    $display("table test done");
    @(posedge clk_i);
    rsd_i <= 1'b1;
    lock_i <= 1'b1;
    neg(1'b1, 1'b1, 1'b1);
    rd(5'h12, 16'h1f00);
    rd(5'h12, 16'h0f00);
    @(posedge clk_i);
    rsd_i <= 1'b0;
    neg(1'b0, 1'b1, 1'b0);
    rd(5'h12, 16'h0900);
    $display("negotiation test done");
    for (int c = 0; c < 9; c++) begin
      wr(5'h17, {8'h00, c[3:0], c[3:0]});
      repeat (2) @(posedge clk_i);
      #1;
      chk({14'h0000, second_led_o, first_led_o}, {14'h0000, {2{LED_MAP[c]}}});
    end
    wr(5'h17, 16'h0018);
    activity_i <= 1'b1;
    @(posedge clk_i);
    activity_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({14'h0000, second_led_o, first_led_o}, 16'h0002);
    repeat (BLINK + 2) @(posedge clk_i);
    #1;
    chk({14'h0000, second_led_o, first_led_o}, 16'h0001);
    @(posedge clk_i);
    link_good_i <= 1'b0;
    repeat (2) @(posedge clk_i);
    #1;
    chk({14'h0000, second_led_o, first_led_o}, 16'h0000);
    $display("indicator test done");
    // A failure and a read of the diagnostic register in one cycle: the set wins.
    @(posedge clk_i);
    rd_en_i <= 1'b1;
    addr_i <= 5'h12;
    neg_done_i <= 1'b1;
    neg_fail_i <= 1'b1;
    neg_fdx_i <= 1'b0;
    neg_spd_i <= 1'b1;
    @(posedge clk_i);
    rd_en_i <= 1'b0;
    neg_done_i <= 1'b0;
    #1;
    chk(rd_data_o, 16'h0900);
    rd(5'h12, 16'h1500);
    rd(5'h12, 16'h0500);
    $display("set and clear test done");
    close_out();
  end
endmodule

`default_nettype wire
